/* hw/power_fail_supervisor.sv */
// supply supervisor: power-on and brownout reset, early warning interrupt
// assumes comparator outputs and sfr strobes synchronous to core_clk
`timescale 1ns/100ps
module power_fail_supervisor
    import pfs_pkg::*;
#(
    parameter int POWERUP_CLOCKS = POWERUP_CLOCKS_DEFAULT
) (
    input  wire logic        core_clk,
    input  wire logic        reset_n,
    input  wire logic        belowResetLevel,
    input  wire logic        belowWarningLevel,
    input  wire logic [7:0]  sfrAddr,
    input  wire logic        sfrWrEn,
    input  wire logic [7:0]  sfrWrData,
    input  wire logic        userIrqReq,
    input  wire logic [15:0] userIrqVector,
    output logic             coreReset,
    output logic             pfIrq,
    output logic             irqReq,
    output logic [15:0]      irqVector,
    output logic [7:0]       sfrRdData
);
    pfs_cnt_if link ();

    sup_state_t stateFf;
    sup_state_t nxtState;
    logic       ctrlWrite;

    power_up_counter #(
        .POWERUP_CLOCKS (POWERUP_CLOCKS)
    ) u_counter (
        .core_clk (core_clk),
        .reset_n  (reset_n),
        .link     (link)
    );

    assign link.supplyLow = belowResetLevel;
    assign ctrlWrite      = sfrWrEn && (sfrAddr == SUPERVISOR_CONTROL_ADDR);

    always_comb begin
        nxtState = stateFf;
        // reset held while supply low or count not finished
        nxtState.coreReset = belowResetLevel || !link.done;
        if (ctrlWrite) begin
            nxtState.pfEnable = sfrWrData[PF_ENABLE_BIT];
            if (!sfrWrData[PF_FLAG_BIT]) begin
                nxtState.pfFlag = 1'h0;
            end
        end
        // set wins over a clear in the same cycle
        if (belowWarningLevel) begin
            nxtState.pfFlag = 1'h1;
        end
        nxtState.pfIrq = nxtState.pfFlag && nxtState.pfEnable;
        nxtState.irqReq = nxtState.pfIrq || userIrqReq;
        if (nxtState.pfIrq) begin
            nxtState.irqVector = PF_VECTOR;
        end else begin
            nxtState.irqVector = userIrqVector;
        end
        nxtState.rdData = READ_ZERO;
        if (sfrAddr == SUPERVISOR_CONTROL_ADDR) begin
            nxtState.rdData[PF_ENABLE_BIT] = nxtState.pfEnable;
            nxtState.rdData[PF_FLAG_BIT]   = nxtState.pfFlag;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            stateFf           <= '0;
            stateFf.coreReset <= 1'h1;
            stateFf.pfEnable  <= PF_ENABLE_RESET;
            stateFf.pfFlag    <= PF_FLAG_RESET;
        end else begin
            stateFf <= nxtState;
        end
    end

    assign coreReset = stateFf.coreReset;
    assign pfIrq     = stateFf.pfIrq;
    assign irqReq    = stateFf.irqReq;
    assign irqVector = stateFf.irqVector;
    assign sfrRdData = stateFf.rdData;

    // cycles the supply has stayed good, saturating at the release point
    localparam logic [COUNT_W-1:0] GOOD_LIMIT = COUNT_W'(POWERUP_CLOCKS + 1);
    logic [COUNT_W-1:0] goodCntFf;

    always_ff @(posedge core_clk) begin
        if (!reset_n || belowResetLevel) begin
            goodCntFf <= '0;
        end else if (goodCntFf != GOOD_LIMIT) begin
            goodCntFf <= goodCntFf + COUNT_W'(1);
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    // supply, reset and power-up count
    a_hold_low_supply : assert property (
        belowResetLevel |=> coreReset)
        else $error("reset released while supply low");

    a_release_after_count : assert property (
        !coreReset |-> goodCntFf == GOOD_LIMIT)
        else $error("reset released before count done");

    a_release_on_time : assert property (
        goodCntFf == GOOD_LIMIT |-> !coreReset)
        else $error("reset not released after count");

    a_brownout_reset : assert property (
        !coreReset ##0 belowResetLevel |=> coreReset [*2])
        else $error("brownout did not assert reset");

    a_reset_outputs : assert property (@(posedge core_clk) disable iff (1'b0)
        !reset_n
        |=> coreReset && !pfIrq && !irqReq && irqVector == '0 && sfrRdData == READ_ZERO)
        else $error("outputs not cleared by reset");

    a_release_needs_done : assert property (
        !coreReset
        |-> link.done)
        else $error("reset released before counter done");

    a_stay_released : assert property (
        !coreReset && !belowResetLevel
        |=> !coreReset)
        else $error("reset raised while supply good");

    a_rise_on_brownout : assert property (
        $rose(coreReset)
        |-> $past(belowResetLevel))
        else $error("reset raised without low supply");

    a_count_restarted : assert property (
        belowResetLevel ##1 !belowResetLevel
        |=> coreReset)
        else $error("reset released right after recovery");

    // register writes and reads
    a_enable_write : assert property (
        ctrlWrite |=> stateFf.pfEnable == $past(sfrWrData[PF_ENABLE_BIT]))
        else $error("enable bit not written");

    a_enable_cleared : assert property (
        ctrlWrite && !sfrWrData[PF_ENABLE_BIT]
        |=> !stateFf.pfEnable && !pfIrq)
        else $error("disable write left interrupt on");

    a_enable_held : assert property (
        !ctrlWrite
        |=> $stable(stateFf.pfEnable))
        else $error("enable bit changed without write");

    a_read_unmapped : assert property (
        sfrAddr != SUPERVISOR_CONTROL_ADDR
        |=> sfrRdData == READ_ZERO)
        else $error("unmapped address read nonzero");

    a_read_control : assert property (
        sfrAddr == SUPERVISOR_CONTROL_ADDR
        |=> sfrRdData[PF_ENABLE_BIT] == stateFf.pfEnable && sfrRdData[PF_FLAG_BIT] == stateFf.pfFlag)
        else $error("control register read wrong");

    // warning flag and interrupt path
    a_vector_taken : assert property (
        belowWarningLevel && !ctrlWrite && stateFf.pfEnable |=> pfIrq && irqReq && irqVector == PF_VECTOR)
        else $error("power-fail vector not raised");

    a_flag_set : assert property (
        belowWarningLevel
        |=> stateFf.pfFlag && ($past(sfrAddr) != SUPERVISOR_CONTROL_ADDR || sfrRdData[PF_FLAG_BIT]))
        else $error("warning flag not set");

    a_flag_sticky : assert property (
        stateFf.pfFlag && !(ctrlWrite && !sfrWrData[PF_FLAG_BIT]) |=> stateFf.pfFlag)
        else $error("warning flag cleared without write");

    a_priority_top : assert property (
        pfIrq |-> irqReq && irqVector == PF_VECTOR)
        else $error("power-fail interrupt lost priority");

    a_flag_cleared : assert property (
        ctrlWrite && !sfrWrData[PF_FLAG_BIT] && !belowWarningLevel
        |=> !stateFf.pfFlag)
        else $error("flag not cleared by write");

    a_flag_only_warning : assert property (
        !stateFf.pfFlag && !belowWarningLevel
        |=> !stateFf.pfFlag)
        else $error("flag set without warning");

    a_set_beats_clear : assert property (
        ctrlWrite && !sfrWrData[PF_FLAG_BIT] && belowWarningLevel
        |=> stateFf.pfFlag)
        else $error("clear won over warning");

    a_irq_needs_both : assert property (
        pfIrq
        |-> stateFf.pfFlag && stateFf.pfEnable)
        else $error("interrupt without flag and enable");

    a_irq_follows_flag : assert property (
        stateFf.pfFlag && stateFf.pfEnable
        |-> pfIrq)
        else $error("interrupt missing with flag and enable");

    a_user_request : assert property (
        !pfIrq && $past(reset_n)
        |-> irqReq == $past(userIrqReq))
        else $error("user request not passed through");

    a_user_vector : assert property (
        !pfIrq && $past(reset_n)
        |-> irqVector == $past(userIrqVector))
        else $error("user vector not passed through");

    // main scenarios
    c_power_up      : cover property ($fell(coreReset));
    c_brownout      : cover property (!coreReset ##1 coreReset);
    c_pf_over_user  : cover property (pfIrq && userIrqReq);
    c_clear_and_set : cover property (ctrlWrite && !sfrWrData[PF_FLAG_BIT] && belowWarningLevel);
    c_flag_clear    : cover property (ctrlWrite && !sfrWrData[PF_FLAG_BIT] && stateFf.pfFlag && !belowWarningLevel);
endmodule // power_fail_supervisor

/* pkg/pfs_pkg.sv */
// constants and state types for the supply supervisor
// assumes one 100 MHz core clock and synchronous comparator inputs
// How it works
// - hold reset while supply below reset threshold
// - count 65536 clocks before releasing reset
// - brownout below threshold asserts and holds reset
// - control bit 5 at D8h enables warning interrupt
// - enabled warning vectors execution to 0033h
// - warning sets flag bit 4 regardless of enable
// - warning interrupt outranks every other interrupt
package pfs_pkg;
    localparam logic [7:0]  SUPERVISOR_CONTROL_ADDR = 8'hd8;
    localparam int          PF_ENABLE_BIT           = 5;
    localparam int          PF_FLAG_BIT             = 4;
    localparam logic        PF_ENABLE_RESET         = 1'h0;
    localparam logic        PF_FLAG_RESET           = 1'h0;
    localparam logic [15:0] PF_VECTOR               = 16'h0033;
    localparam logic [7:0]  READ_ZERO               = 8'h00;
    localparam int          POWERUP_CLOCKS_DEFAULT  = 65536;
    localparam int          COUNT_W                 = 18;

    typedef struct packed {
        logic        coreReset;
        logic        pfEnable;
        logic        pfFlag;
        logic        irqReq;
        logic        pfIrq;
        logic [15:0] irqVector;
        logic [7:0]  rdData;
    } sup_state_t;

    typedef struct packed {
        logic [COUNT_W-1:0] count;
        logic               done;
    } cnt_state_t;
endpackage

/* pkg/pfs_cnt_if.sv */
// link between the supervisor and its power-up counter
// assumes both ends share core_clk
`timescale 1ns/100ps
interface pfs_cnt_if;
    import pfs_pkg::*;
    logic               supplyLow;
    logic               done;
    logic [COUNT_W-1:0] count;
    modport ctrl (output supplyLow, input done, input count);
    modport cnt  (input supplyLow, output done, output count);
endinterface

/* hw/power_up_counter.sv */
// power-up delay counter, cleared while the supply is low
// assumes supplyLow is synchronous to core_clk
`timescale 1ns/100ps
module power_up_counter
    import pfs_pkg::*;
#(
    parameter int POWERUP_CLOCKS = POWERUP_CLOCKS_DEFAULT
) (
    input  wire logic core_clk,
    input  wire logic reset_n,
    pfs_cnt_if.cnt    link
);
    localparam logic [COUNT_W-1:0] LAST = COUNT_W'(POWERUP_CLOCKS);

    cnt_state_t stateFf;
    cnt_state_t nxtState;

    always_comb begin
        nxtState = stateFf;
        if (link.supplyLow) begin
            nxtState.count = '0;
        end else if (stateFf.count != LAST) begin
            nxtState.count = stateFf.count + COUNT_W'(1);
        end
        nxtState.done = !link.supplyLow && (nxtState.count == LAST);
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            stateFf <= '0;
        end else begin
            stateFf <= nxtState;
        end
    end

    assign link.done  = stateFf.done;
    assign link.count = stateFf.count;

    a_count_restart : assert property (@(posedge core_clk) disable iff (!reset_n)
        link.supplyLow |=> (link.count == '0) && !link.done)
        else $error("count not cleared by low supply");
endmodule // power_up_counter

/* verif/core_model.sv */
// core side: takes one interrupt each time the request rises
// assumes registered request and vector on core_clk
`timescale 1ns/100ps
module core_model (
    input  wire logic        core_clk,
    input  wire logic        coreReset,
    input  wire logic        irqReq,
    input  wire logic [15:0] irqVector,
    output logic             taken,
    output logic [15:0]      takenVec
);
    logic busy = 1'b0;
    initial taken = 1'b0;
    initial takenVec = 16'h0000;
    always @(posedge core_clk) begin
        taken <= 1'b0;
        if (coreReset) begin
            busy <= 1'b0;
        end else if (irqReq && !busy) begin
            taken <= 1'b1;
            takenVec <= irqVector;
            busy <= 1'b1;
        end else if (!irqReq) begin
            busy <= 1'b0;
        end
    end
endmodule // core_model

/* verif/test_power_fail_supervisor.sv */
// bench for the supply supervisor with a core model
// assumes a short power-up count
`timescale 1ns/100ps
module test_power_fail_supervisor;
    import pfs_pkg::*;
    localparam int N = 16;
    logic        core_clk, reset_n, belowResetLevel, belowWarningLevel, sfrWrEn, userIrqReq;
    logic        coreReset, pfIrq, irqReq, taken;
    logic [7:0]  sfrAddr, sfrWrData, sfrRdData, a;
    logic [15:0] userIrqVector, irqVector, takenVec;
    logic [15:0] expQ[$];
    logic [31:0] seed = 32'h83b890ee;
    int          nMismatch = 0, comparisons = 0, cyc = 0;
    power_fail_supervisor #(.POWERUP_CLOCKS(N)) i_dut (.core_clk(core_clk), .reset_n(reset_n),
        .belowResetLevel(belowResetLevel), .belowWarningLevel(belowWarningLevel), .sfrAddr(sfrAddr),
        .sfrWrEn(sfrWrEn), .sfrWrData(sfrWrData), .userIrqReq(userIrqReq), .userIrqVector(userIrqVector),
        .coreReset(coreReset), .pfIrq(pfIrq), .irqReq(irqReq), .irqVector(irqVector), .sfrRdData(sfrRdData));
    core_model i_core (.core_clk(core_clk), .coreReset(coreReset), .irqReq(irqReq), .irqVector(irqVector),
        .taken(taken), .takenVec(takenVec));
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic cmp(logic [15:0] got, logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            nMismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wrapUp();
        $display("comparisons %0d mismatches %0d", comparisons, nMismatch);
        if (nMismatch == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic tick(int n);
        repeat (n) @(posedge core_clk);
    endtask
    task automatic wr(logic [7:0] ad, logic [7:0] d);
        @(posedge core_clk) {sfrAddr, sfrWrData, sfrWrEn} <= {ad, d, 1'b1};
        @(posedge core_clk) sfrWrEn <= 1'b0;
    endtask
    task automatic rd(logic [7:0] ad, logic [7:0] exp);
        @(posedge core_clk) sfrAddr <= ad;
        @(posedge core_clk) #1 cmp(sfrRdData, exp);
    endtask
    task automatic release_in(int lo);
        int n;
        n = 0;
        while (coreReset !== 1'b0 && n < 4 * N) begin
            @(posedge core_clk) #1 n++;
        end
        cmp(n >= lo && n <= N + 2, 1'b1);
    endtask
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            nMismatch++;
            wrapUp();
        end
    end
    always @(negedge core_clk) if (taken === 1'b1) cmp(takenVec, expQ.size() ? expQ.pop_front() : 'x);
    initial begin
        {reset_n, belowResetLevel, belowWarningLevel, sfrWrEn, userIrqReq} = '0;
        {sfrAddr, sfrWrData, userIrqVector} = '0;
        tick(20);
        reset_n <= 1'b1;
        release_in(N);
        rd(SUPERVISOR_CONTROL_ADDR, 8'h00);
        repeat (4) begin
            a = 8'(xs());
            if (a == SUPERVISOR_CONTROL_ADDR) a = 8'h00;
            wr(a, 8'(xs()));
            rd(a, READ_ZERO);
        end
        rd(SUPERVISOR_CONTROL_ADDR, 8'h00);
        @(posedge core_clk) belowResetLevel <= 1'b1;
        repeat (30) @(posedge core_clk) #1 cmp(coreReset, 1'b1);
        @(posedge core_clk) belowResetLevel <= 1'b0;
        tick(N - 4);
        belowResetLevel <= 1'b1;
        tick(1);
        belowResetLevel <= 1'b0;
        release_in(N + 1);
        @(posedge core_clk) {userIrqVector, userIrqReq, belowWarningLevel} <= {16'(xs()), 2'b11};
        expQ.push_back(seed[15:0]);
        tick(2);
        #1 cmp(pfIrq, 1'b0);
        @(posedge core_clk) {userIrqReq, belowWarningLevel} <= 2'b00;
        rd(SUPERVISOR_CONTROL_ADDR, 8'h10);
        expQ.push_back(PF_VECTOR);
        wr(SUPERVISOR_CONTROL_ADDR, 8'h30);
        @(posedge core_clk) userIrqReq <= 1'b1;
        tick(2);
        #1 cmp(irqVector, PF_VECTOR);
        rd(SUPERVISOR_CONTROL_ADDR, 8'h30);
        wr(SUPERVISOR_CONTROL_ADDR, 8'h20);
        tick(1);
        #1 cmp(pfIrq, 1'b0);
        cmp(irqVector, userIrqVector);
        @(posedge core_clk) {userIrqReq, belowWarningLevel} <= 2'b01;
        wr(SUPERVISOR_CONTROL_ADDR, 8'h00);
        rd(SUPERVISOR_CONTROL_ADDR, 8'h10);
        cmp(16'(expQ.size()), 16'h0000);
        wrapUp();
    end
endmodule // test_power_fail_supervisor
